// *** verilog/timer_pkg.sv ***
//----------------------------------------------------------------------
// Purpose: shared constants and types for the three counter interval timer
//----------------------------------------------------------------------
// Assumes: byte wide host port, counting clocks sampled on clk_i
// Notes:   counts are held as 16 bits, four bcd digits in decimal format
package timer_pkg;
   localparam int NUM_CNT = 3;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 8;
   // port offsets
   localparam logic [ADDR_W-1:0] OFS_CNT0 = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_CNT1 = 8'h22;
   localparam logic [ADDR_W-1:0] OFS_CNT2 = 8'h24;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h26;
   // control word field positions
   localparam int SEL_HI = 7;
   localparam int SEL_LO = 6;
   localparam int ACC_HI = 5;
   localparam int ACC_LO = 4;
   localparam int MODE_TOP = 3;
   localparam int MODE_BOT = 1;
   localparam int BCD_BIT = 0;
   // field codes
   localparam logic [1:0] SEL_ILLEGAL = 2'h3;
   localparam logic [1:0] ACC_LATCH = 2'h0;
   localparam logic [1:0] ACC_LOW = 2'h1;
   localparam logic [1:0] ACC_HIGH = 2'h2;
   localparam logic [1:0] ACC_BOTH = 2'h3;
   // count values
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_TWO = 16'h0002;
   localparam logic [3:0] BCD_NINE = 4'h9;
   localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
   // timing: fastest counting clock and its period in system cycles
   localparam longint CLK_HZ = 200000000;
   localparam longint MAX_COUNT_CLK_HZ = 5000000;
   localparam int COUNT_CLK_MIN_CYC = int'(CLK_HZ / MAX_COUNT_CLK_HZ);

   typedef enum logic [2:0] {
      MODE_TC_INT,
      MODE_ONE_SHOT,
      MODE_RATE,
      MODE_SQUARE,
      MODE_SW_STROBE,
      MODE_HW_STROBE
   } mode_type;

   // mode field to mode, top bit ignored when middle bit is set
   function automatic mode_type decode_mode(input logic [2:0] f);
      mode_type m;
      m = MODE_TC_INT;
      if (f[1]) begin
         m = f[0] ? MODE_SQUARE : MODE_RATE;
      end else begin
         case ({f[2], f[0]})
            2'h0: m = MODE_TC_INT;
            2'h1: m = MODE_ONE_SHOT;
            2'h2: m = MODE_SW_STROBE;
            default: m = MODE_HW_STROBE;
         endcase
      end
      return m;
   endfunction
endpackage

// *** verilog/ctr_if.sv ***
//----------------------------------------------------------------------
// Purpose: link between channel control and its down counter
//----------------------------------------------------------------------
// Assumes: one instance per channel
// Notes:   load wins over tick in the counter
`timescale 1ns/1ps
`default_nettype none
interface ctr_if;
   import timer_pkg::*;
   logic load;
   logic [CNT_W-1:0] value;
   logic tick;
   logic step2;
   logic bcd;
   logic [CNT_W-1:0] count;
   modport ctl(output load, output value, output tick, output step2, output bcd, input count);
   modport core(input load, input value, input tick, input step2, input bcd, output count);
endinterface
`default_nettype wire

// *** verilog/edge_detect.sv ***
//----------------------------------------------------------------------
// Purpose: rising edge detection of synchronous level inputs
//----------------------------------------------------------------------
// Assumes: inputs synchronous to clk_i
// Notes:   pulse lasts one cycle, frozen while ce_i is low
`timescale 1ns/1ps
`default_nettype none
module edge_detect #(
   parameter int W = 1
) (
   input wire logic clk_i,          // system clock
   input wire logic rst_i,          // synchronous reset
   input wire logic ce_i,           // clock enable
   input wire logic [W-1:0] sig_i,  // levels to watch
   output logic [W-1:0] rise_o      // one cycle per rising edge
);
   logic [W-1:0] prev;

   // previous level, pin level at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev <= sig_i;
      end else if (ce_i) begin
         prev <= sig_i;
      end
   end

   assign rise_o = sig_i & ~prev & {W{ce_i}};
endmodule
`default_nettype wire

// *** verilog/count_core.sv ***
//----------------------------------------------------------------------
// Purpose: 16 bit down counter, binary or four digit bcd
//----------------------------------------------------------------------
// Assumes: tick is one cycle per counting clock edge
// Notes:   zero wraps to the top count of the chosen format
`timescale 1ns/1ps
`default_nettype none
module count_core
   import timer_pkg::*;
(
   input wire logic clk_i,  // system clock
   input wire logic rst_i,  // synchronous reset
   input wire logic ce_i,   // clock enable
   ctr_if.core cif          // load, tick and count
);
   // one step down, digit wise borrow in bcd
   function automatic logic [CNT_W-1:0] dec_one(input logic [CNT_W-1:0] v, input logic bcd);
      logic [CNT_W-1:0] r;
      logic borrow;
      r = v;
      borrow = 1'b1;
      if (!bcd) begin
         r = v - CNT_ONE; // see RQ10
      end else begin
         for (int i = 0; i < CNT_W / 4; i++) begin
            if (borrow) begin
               if (v[4*i+:4] == 4'h0) begin
                  r[4*i+:4] = BCD_NINE; // see RQ10
               end else begin
                  r[4*i+:4] = v[4*i+:4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction

   wire [CNT_W-1:0] once = dec_one(cif.count, cif.bcd);
   wire [CNT_W-1:0] twice = dec_one(once, cif.bcd);

   // load or step
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cif.count <= CNT_ZERO;
      end else if (ce_i) begin
         if (cif.load) begin
            cif.count <= cif.value;
         end else if (cif.tick) begin
            cif.count <= cif.step2 ? twice : once; // see RQ9
         end
      end
   end
endmodule
`default_nettype wire

// *** verilog/three_counter_interval_timer.sv ***
//----------------------------------------------------------------------
// Purpose: three channel programmable interval timer on a byte port
//----------------------------------------------------------------------
// Assumes: one cycle wr_i/rd_i strobes, count clocks and gates synchronous
// Notes:   read data appears on rdata_o the cycle after rd_i
//
// What this block does
// RQ1: three separate 16 bit down counters, each programmed on its own.
// RQ2: each counting clock may run from standstill up to 5 MHz.
// RQ3: each counter runs in one of six modes chosen by its control byte.
// RQ4: data ports sit at offsets 20, 22, 24 and the control byte at 26.
// RQ5: software writes a counter's control byte before loading or reading it.
// RQ6: control bits 7:6 pick counter 0, 1 or 2; code 3 is illegal and ignored.
// RQ7: control bits 5:4 pick latch, low byte, high byte, or low then high.
// RQ8: control bits 3:1 pick the mode, top bit ignored for modes 2 and 3.
// RQ9: control bit 0 picks binary or four digit decimal counting.
// RQ10: binary counts span 0 to 65535, decimal counts 0 to 9999.
// RQ11: modes are terminal count, one-shot, rate, square wave, soft and hard strobe.
// RQ12: output and gate follow the usual interval timer conventions per mode.
// RQ13: a counter stays idle after reset until control byte and count arrive; a count write alone starts it in mode 0.
`timescale 1ns/1ps
`default_nettype none
module three_counter_interval_timer
   import timer_pkg::*;
(
   input wire logic clk_i,                   // system clock
   input wire logic rst_i,                   // synchronous reset
   input wire logic ce_i,                    // clock enable
   input wire logic [ADDR_W-1:0] addr_i,     // port offset
   input wire logic [DATA_W-1:0] wdata_i,    // write byte
   input wire logic wr_i,                    // write strobe
   input wire logic rd_i,                    // read strobe
   output logic [DATA_W-1:0] rdata_o,        // read byte
   input wire logic [NUM_CNT-1:0] cnt_clk_i, // counting clocks
   input wire logic [NUM_CNT-1:0] gate_i,    // gates
   output logic [NUM_CNT-1:0] out_o          // counter outputs
);
   //----------------------------------------------------------------------
   // port decode
   //----------------------------------------------------------------------
   // data port hit for one counter
   function automatic logic port_hit(input logic [ADDR_W-1:0] a, input int i);
      logic h;
      h = 1'b0;
      case (i)
         0: h = (a == OFS_CNT0); // see RQ4
         1: h = (a == OFS_CNT1);
         2: h = (a == OFS_CNT2);
         default: h = 1'b0;
      endcase
      return h;
   endfunction

   wire ctrl_hit = (addr_i == OFS_CTRL); // see RQ4

   // control byte fields
   wire [1:0] sel = wdata_i[SEL_HI:SEL_LO];
   wire [1:0] acc_f = wdata_i[ACC_HI:ACC_LO];
   wire ctrl_wr = ce_i & wr_i & ctrl_hit & (sel != SEL_ILLEGAL); // see RQ6
   wire mode_type mode_f = decode_mode(wdata_i[MODE_TOP:MODE_BOT]); // see RQ8
   wire bcd_f = wdata_i[BCD_BIT]; // see RQ9

   //----------------------------------------------------------------------
   // edge detection of counting clocks and gates
   //----------------------------------------------------------------------
   // one cycle pulses
   logic [NUM_CNT-1:0] clk_rise;
   logic [NUM_CNT-1:0] gate_rise;

   // counting clocks up to CLK_HZ/2 are seen, the 5 MHz top is far below
   edge_detect #(.W(2 * NUM_CNT)) u_edges ( // see RQ2
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .sig_i({gate_i, cnt_clk_i}),
      .rise_o({gate_rise, clk_rise})
   );

   // per channel read byte
   logic [DATA_W-1:0] rbyte [NUM_CNT];
   logic [NUM_CNT-1:0] rhit;

   //----------------------------------------------------------------------
   // channels
   //----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_CNT; g++) begin : ch // see RQ1
         ctr_if cif();

         // mode and format
         mode_type mode;
         logic [1:0] acc;
         logic bcd;
         logic wr_hi;
         logic rd_hi;

         // counts
         logic [DATA_W-1:0] lo_stage;
         logic [CNT_W-1:0] reload;
         logic [CNT_W-1:0] latch_val;
         logic latched;

         // run state
         logic pending;
         logic has_count;
         logic running;
         logic trig;
         logic out;

         // strobes for this channel
         wire prog = ctrl_wr & (sel == 2'(g)) & (acc_f != ACC_LATCH);
         wire latch_cmd = ctrl_wr & (sel == 2'(g)) & (acc_f == ACC_LATCH);
         wire dwr = ce_i & wr_i & port_hit(addr_i, g);
         wire drd = ce_i & rd_i & port_hit(addr_i, g);
         wire tick = clk_rise[g];

         // mode classes
         wire m0 = (mode == MODE_TC_INT);
         wire m1 = (mode == MODE_ONE_SHOT);
         wire m2 = (mode == MODE_RATE);
         wire m3 = (mode == MODE_SQUARE);
         wire m4 = (mode == MODE_SW_STROBE);
         wire m5 = (mode == MODE_HW_STROBE);

         // modes 1, 5 ignore gate level
         wire trig_mode = m1 | m5 | m2 | m3;
         wire gate_ok = gate_i[g] | m1 | m5; // see RQ12

         // write assembly: low, high, or low then high
         wire wr_first = dwr & (acc == ACC_BOTH) & !wr_hi;
         wire wr_done = dwr & !wr_first; // see RQ7
         wire [CNT_W-1:0] new_count =
            (acc == ACC_LOW) ? {BYTE_ZERO, wdata_i} :
            (acc == ACC_HIGH) ? {wdata_i, BYTE_ZERO} :
            {wdata_i, lo_stage};

         // terminal handling of the periodic modes
         wire [CNT_W-1:0] cnt = cif.count;
         wire at_one = (cnt == CNT_ONE);
         wire rate_end = m2 & at_one;
         // steps of two end at 2 or 1
         wire sq_end = m3 & (cnt <= CNT_TWO) & (cnt != CNT_ZERO);

         // counted tick
         wire run_tick = tick & running & gate_ok;

         // load decision: new count, trigger, or period reload
         // periodic modes load when stopped
         wire first_load = pending & (m0 | m4 | ((m2 | m3) & !running));
         wire trig_load = trig & trig_mode & has_count;
         wire do_load = tick & (first_load | trig_load) |
                        run_tick & (rate_end | sq_end); // see RQ11
         wire do_dec = run_tick & !do_load;

         // count write wins
         assign cif.load = do_load & !wr_done;
         assign cif.value = reload;
         assign cif.tick = do_dec & !wr_done;
         assign cif.step2 = m3; // see RQ12
         assign cif.bcd = bcd;

         // down counter
         count_core u_core (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .cif(cif)
         );

         // control word and count programming
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               mode <= MODE_TC_INT;
               acc <= ACC_LATCH;
               bcd <= 1'b0;
               wr_hi <= 1'b0;
               lo_stage <= BYTE_ZERO;
               reload <= CNT_ZERO;
               pending <= 1'b0;
               has_count <= 1'b0; // see RQ13
            end else if (ce_i) begin
               if (prog) begin // see RQ3
                  mode <= mode_f;
                  acc <= acc_f;
                  bcd <= bcd_f;
                  wr_hi <= 1'b0;
                  pending <= 1'b0;
                  has_count <= 1'b0;
               end else if (wr_first) begin
                  lo_stage <= wdata_i;
                  wr_hi <= 1'b1;
               end else if (wr_done) begin
                  reload <= new_count;
                  wr_hi <= 1'b0;
                  pending <= 1'b1;
                  has_count <= 1'b1;
               end else if (tick & first_load) begin
                  pending <= 1'b0;
               end else if (do_load & pending) begin
                  pending <= 1'b0;
               end
            end
         end

         // run state, trigger and output level
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               running <= 1'b0;
               trig <= 1'b0;
               out <= 1'b0;
            end else if (ce_i) begin
               if (prog) begin
                  running <= 1'b0;
                  trig <= 1'b0;
                  out <= (mode_f != MODE_TC_INT); // see RQ12
               // mode 0 write stops it
               end else if (wr_done | wr_first & m0) begin
                  running <= running & !m0;
                  out <= m0 ? 1'b0 : out;
               end else if (gate_rise[g] & trig_mode) begin
                  trig <= 1'b1; // see RQ12
               end else if ((m2 | m3) & !gate_i[g]) begin
                  out <= 1'b1;
               end else if (do_load) begin
                  running <= 1'b1;
                  trig <= 1'b0;
                  out <= m1 ? 1'b0 : (m3 & running) ? !out : !m0;
               end else if (do_dec) begin
                  if (at_one & (m0 | m1)) begin
                     out <= 1'b1;
                  end else if (at_one & (m4 | m5)) begin
                     out <= 1'b0;
                  end else if (m2 & (cnt == CNT_TWO)) begin
                     out <= 1'b0;
                  end else if (m4 | m5) begin
                     out <= 1'b1;
                  end
               end
            end
         end

         // count latch and read byte order
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               latched <= 1'b0;
               latch_val <= CNT_ZERO;
               rd_hi <= 1'b0;
            end else if (ce_i) begin
               if (prog) begin
                  latched <= 1'b0;
                  rd_hi <= 1'b0;
               // repeat latch ignored
               end else if (latch_cmd & !latched) begin
                  latched <= 1'b1; // see RQ7
                  latch_val <= cnt;
               end else if (drd) begin
                  rd_hi <= (acc == ACC_BOTH) & !rd_hi;
                  if ((acc != ACC_BOTH) | rd_hi) begin
                     latched <= 1'b0;
                  end
               end
            end
         end

         // byte selection for a read
         wire [CNT_W-1:0] rsrc = latched ? latch_val : cnt;
         wire take_hi = (acc == ACC_HIGH) | ((acc == ACC_BOTH) & rd_hi);
         assign rbyte[g] = take_hi ? rsrc[CNT_W-1:DATA_W] : rsrc[DATA_W-1:0];

         // hit and pin
         assign rhit[g] = drd;
         assign out_o[g] = out;
      end
   endgenerate

   //----------------------------------------------------------------------
   // read data register
   //----------------------------------------------------------------------
   // byte for the next read
   logic [DATA_W-1:0] next_rdata;

   // selected byte, zero for the control port and unused offsets
   always_comb begin
      next_rdata = BYTE_ZERO;
      for (int i = 0; i < NUM_CNT; i++) begin
         if (rhit[i]) begin
            next_rdata = rbyte[i];
         end
      end
   end

   // capture on each read strobe
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= BYTE_ZERO;
      end else if (ce_i & rd_i) begin
         rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// *** tb/three_counter_interval_timer_properties.sv ***
//----------------------------------------------------------------------
// Purpose: port level checks for the three counter interval timer
//----------------------------------------------------------------------
// Assumes: strobes, counting clocks and gates synchronous to clk_i
// Notes:   out_o may move only after a write, a counting edge or a gate change
`timescale 1ns/1ps
`default_nettype none
module three_counter_interval_timer_properties
   import timer_pkg::*;
(
   input wire logic clk_i,                   // system clock
   input wire logic rst_i,                   // synchronous reset
   input wire logic ce_i,                    // clock enable
   input wire logic [ADDR_W-1:0] addr_i,     // port offset
   input wire logic [DATA_W-1:0] wdata_i,    // write byte
   input wire logic wr_i,                    // write strobe
   input wire logic rd_i,                    // read strobe
   input wire logic [DATA_W-1:0] rdata_o,    // read byte
   input wire logic [NUM_CNT-1:0] cnt_clk_i, // counting clocks
   input wire logic [NUM_CNT-1:0] gate_i,    // gates
   input wire logic [NUM_CNT-1:0] out_o      // counter outputs
);
   logic [NUM_CNT-1:0] prev_clk;
   logic [NUM_CNT-1:0] prev_gate;
   logic written;
   logic [1:0] sel_q;
   logic lvl_q;
   // ----------------------------------------------------------------------
   // helper state: edges seen as the design sees them, frozen by ce_i
   // ----------------------------------------------------------------------
   wire logic pin_act = ce_i && ((|(cnt_clk_i & ~prev_clk)) || (|(gate_i ^ prev_gate)));
   wire logic cause = pin_act || (ce_i && wr_i);
   wire logic map_rd = (addr_i == OFS_CNT0) || (addr_i == OFS_CNT1) || (addr_i == OFS_CNT2);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_clk <= cnt_clk_i;
         prev_gate <= gate_i;
         written <= 1'b0;
      end else if (ce_i) begin
         prev_clk <= cnt_clk_i;
         prev_gate <= gate_i;
         written <= written | wr_i;
      end
   end
   // selected counter and its expected start level of the last write
   always_ff @(posedge clk_i) begin
      sel_q <= wdata_i[7:6];
      lvl_q <= wdata_i[2];
   end
   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_ctrl_write;
      ce_i && wr_i && addr_i == OFS_CTRL && wdata_i[7:6] != SEL_ILLEGAL && wdata_i[5:4] != ACC_LATCH
         && (wdata_i[3:1] == 3'h0 || wdata_i[2]);
   endsequence
   sequence s_illegal_write;
      ce_i && wr_i && addr_i == OFS_CTRL && wdata_i[7:6] == SEL_ILLEGAL && !pin_act && !$past(pin_act);
   endsequence
   chk_reset_clear: assert property ($fell(rst_i) |-> rdata_o == BYTE_ZERO && out_o == '0)
      else $error("outputs not cleared by reset");
   chk_idle_reset: assert property (!written |-> out_o == '0)
      else $error("output moved before any write");
   chk_ctrl_level: assert property (s_ctrl_write |=> out_o[sel_q] == lvl_q)
      else $error("wrong output level after control write");
   chk_illegal_ignored: assert property (s_illegal_write |=> $stable(out_o))
      else $error("illegal counter select had an effect");
   chk_read_hold: assert property (!(ce_i && rd_i) |=> $stable(rdata_o))
      else $error("read byte changed without a read");
   chk_unmapped_zero: assert property (ce_i && rd_i && !map_rd |=> rdata_o == BYTE_ZERO)
      else $error("control or unmapped read not zero");
   chk_out_cause: assert property ($changed(out_o) |-> $past(cause) || $past(cause, 2))
      else $error("output moved without a cause");
   chk_ce_freeze: assert property (!ce_i |=> $stable(out_o) && $stable(rdata_o))
      else $error("state moved while clock enable low");
endmodule
bind three_counter_interval_timer three_counter_interval_timer_properties chk (.clk_i(clk_i), .rst_i(rst_i),
   .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .cnt_clk_i(cnt_clk_i), .gate_i(gate_i), .out_o(out_o));
`default_nettype wire

// *** tb/host_model.sv ***
//----------------------------------------------------------------------
// Purpose: host side of the byte port, one access per call
//----------------------------------------------------------------------
// Assumes: inputs change at the falling edge, strobes last one cycle
// Notes:   released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_model
   import timer_pkg::*;
(
   input wire logic clk_i,                // system clock
   input wire logic [DATA_W-1:0] rdata_i, // read byte
   output logic [ADDR_W-1:0] addr_o,      // port offset
   output logic [DATA_W-1:0] wdata_o,     // write byte
   output logic wr_o,                     // write strobe
   output logic rd_o                      // read strobe
);
   initial begin
      addr_o = 8'hFF;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // one write cycle; callers send the control byte first
   task automatic write_port(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(negedge clk_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clk_i);
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
   endtask
   // one read cycle, byte taken once the answering edge has passed
   task automatic read_port(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(negedge clk_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clk_i);
      rd_o = 1'b0;
      addr_o = ~a;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

// *** tb/three_counter_interval_timer_test.sv ***
//----------------------------------------------------------------------
// Purpose: self checking bench for the three counter interval timer
//----------------------------------------------------------------------
// Assumes: counting clocks at the fastest allowed rate, gates held high
// Notes:   each scenario but s_refuse programs one counter and leaves it running; s_refuse programs none
`timescale 1ns/1ps
`default_nettype none
`define CHECK(name, exp, got) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("ERROR %s expected %h seen %h", name, exp, got); end end
module three_counter_interval_timer_test;
   import timer_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ce = 1'b1;
   logic [NUM_CNT-1:0] cnt_clk = '0;
   logic [NUM_CNT-1:0] gate = '1;
   wire logic [ADDR_W-1:0] addr;
   wire logic [DATA_W-1:0] wdata;
   wire logic wr;
   wire logic rd;
   wire logic [DATA_W-1:0] rdata;
   wire logic [NUM_CNT-1:0] out;
   int n_mismatch = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [ADDR_W-1:0] port_addr [NUM_CNT] = '{OFS_CNT0, OFS_CNT1, OFS_CNT2};
   // ----------------------------------------------------------------------
   // clock, instances and watchdog
   // ----------------------------------------------------------------------
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   three_counter_interval_timer dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .cnt_clk_i(cnt_clk), .gate_i(gate), .out_o(out));
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   // one counting clock period at the 5 MHz ceiling
   task automatic tick(input int k);
      @(negedge clk_i);
      cnt_clk[k] = 1'b1;
      repeat (COUNT_CLK_MIN_CYC / 2) @(negedge clk_i);
      cnt_clk[k] = 1'b0;
      repeat (COUNT_CLK_MIN_CYC / 2 - 1) @(negedge clk_i);
   endtask
   // latched count read low byte then high byte
   task automatic read_count(input int k, output logic [CNT_W-1:0] v);
      logic [DATA_W-1:0] lo;
      logic [DATA_W-1:0] hi;
      host.read_port(port_addr[k], lo);
      host.read_port(port_addr[k], hi);
      v = {hi, lo};
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   // terminal count mode on counter 0, low then high, latched mid count
   task automatic s_term_count();
      logic [CNT_W-1:0] v;
      host.write_port(OFS_CTRL, 8'h30);
      `CHECK("mode0 start out", 1'b0, out[0])
      host.write_port(OFS_CNT0, 8'h05);
      host.write_port(OFS_CNT0, 8'h00);
      repeat (5) tick(0);
      `CHECK("mode0 before tc out", 1'b0, out[0])
      host.write_port(OFS_CTRL, 8'h00);
      read_count(0, v);
      `CHECK("mode0 latched count", 16'h0001, v)
      tick(0);
      `CHECK("mode0 tc out", 1'b1, out[0])
   endtask
   // rate mode on counter 1, top mode bit set, low byte only
   task automatic s_rate();
      host.write_port(OFS_CTRL, 8'h5C);
      `CHECK("rate start out", 1'b1, out[1])
      host.write_port(OFS_CNT1, 8'h03);
      repeat (3) tick(1);
      `CHECK("rate low out", 1'b0, out[1])
      tick(1);
      `CHECK("rate reload out", 1'b1, out[1])
      `CHECK("counter 0 untouched", 1'b1, out[0])
   endtask
   // decimal count on counter 2, high byte only, borrow across digits
   task automatic s_decimal();
      logic [DATA_W-1:0] hi;
      host.write_port(OFS_CTRL, 8'hA1);
      host.write_port(OFS_CNT2, 8'h10);
      repeat (2) tick(2);
      host.write_port(OFS_CTRL, 8'h80);
      host.read_port(OFS_CNT2, hi);
      `CHECK("decimal high byte", 8'h09, hi)
   endtask
   // strobe mode on counter 0
   task automatic s_strobe();
      host.write_port(OFS_CTRL, 8'h18);
      host.write_port(OFS_CNT0, 8'h02);
      repeat (3) tick(0);
      `CHECK("strobe low", 1'b0, out[0])
      tick(0);
      `CHECK("strobe end", 1'b1, out[0])
   endtask
   // illegal select, control and unmapped reads, clock enable low
   task automatic s_refuse();
      logic [DATA_W-1:0] d;
      host.write_port(OFS_CTRL, 8'hD0);
      `CHECK("illegal select outs", 3'h3, out)
      host.read_port(OFS_CTRL, d);
      `CHECK("control read", 8'h00, d)
      host.read_port(8'h21, d);
      `CHECK("unmapped read", 8'h00, d)
      @(negedge clk_i);
      ce = 1'b0;
      host.write_port(OFS_CTRL, 8'h10);
      ce = 1'b1;
      `CHECK("frozen outs", 3'h3, out)
   endtask
   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(negedge clk_i);
      rst_i = 1'b0;
      `CHECK("reset out", 3'h0, out)
      `CHECK("reset rdata", 8'h00, rdata)
      s_term_count();
      s_rate();
      s_decimal();
      s_strobe();
      s_refuse();
      stop_test();
   end
endmodule
`default_nettype wire
